/* ccctl_regs.svh */
`ifndef CCCTL_REGS_SVH
`define CCCTL_REGS_SVH

`define CCCTL_IDX_FEATURE      8'he8
`define CCCTL_IDX_TRIGGER      8'heb
`define CCCTL_RST_FEATURE      8'h85
`define CCCTL_RST_TRIGGER      8'h00
`define CCCTL_BIT_IDENT        7
`define CCCTL_BIT_NEST         6
`define CCCTL_BIT_FPFAST       5
`define CCCTL_BIT_DIRCACHE     4
`define CCCTL_BIT_BYPASS       3
`define CCCTL_IO_RECOVERY_CLOCKS_MSB         2
`define CCCTL_BIT_NMI          2
`define CCCTL_BIT_SIMD         0
`define CCCTL_TRIGGER_WMASK    8'h05
`define CCCTL_OPEN_LO0         8'hc1
`define CCCTL_OPEN_HI0         8'hc3
`define CCCTL_OPEN_LO1         8'hcd
`define CCCTL_OPEN_HI1         8'hcf
`define CCCTL_OPEN_LO2         8'hfe
`define CCCTL_OPEN_HI2         8'hff

`endif

/* ccctl_pkg.sv */
package ccctl_pkg;

  typedef struct packed {
    logic       ident_instr_enable;
    logic       mgmt_irq_nest_enable;
    logic       float_fast_enable;
    logic       dir_entry_cache_enable;
    logic       read_bypass_enable;
    logic [2:0] io_recovery_clocks;
  } ccctl_feature_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } ccctl_bus_t;

  typedef enum logic [1:0] {
    CCCTL_IO_IDLE,
    CCCTL_IO_WAIT
  } ccctl_io_state_t;

endpackage

/* ccctl_nmi_pulse.sv */
`timescale 1ns/10ps
module ccctl_nmi_pulse (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic trig,
  output logic      nmi_pulse
);

  typedef struct packed {
    logic trig_d;
    logic pulse;
  } ccctl_nmi_st_t;

  ccctl_nmi_st_t st_r;
  ccctl_nmi_st_t st_nxt;

  always_comb begin
    st_nxt        = st_r;
    st_nxt.trig_d = trig;
    st_nxt.pulse  = trig & ~st_r.trig_d; // one pulse per rising edge only
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign nmi_pulse = st_r.pulse;

endmodule // ccctl_nmi_pulse

/* ccctl_io_gap.sv */
`timescale 1ns/10ps
module ccctl_io_gap #(
  parameter int CNT_W = 8
) (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic [2:0] sel,
  input  wire logic       io_req,
  output logic            io_grant,
  output logic            io_busy
);

  // counter must reach the longest gap, 128 clocks
  if (CNT_W < 8) begin : g_cnt_w_check
    $error("ccctl_io_gap: CNT_W must hold 128");
  end

  typedef struct packed {
    ccctl_pkg::ccctl_io_state_t state;
    logic [CNT_W-1:0]           cnt;
  } ccctl_gap_st_t;

  ccctl_gap_st_t    st_r;
  ccctl_gap_st_t    st_nxt;
  logic [CNT_W-1:0] gap;

  // 000 -> 0, else 2^sel clocks
  always_comb begin
    if (sel == 3'h0) begin
      gap = '0;
    end else begin
      gap = CNT_W'(1) << sel;
    end
  end

  assign io_grant = io_req && (st_r.state == ccctl_pkg::CCCTL_IO_IDLE);
  assign io_busy  = (st_r.state == ccctl_pkg::CCCTL_IO_WAIT);

  always_comb begin
    st_nxt = st_r;
    case (st_r.state)
      ccctl_pkg::CCCTL_IO_IDLE: begin
        if (io_req && gap != '0) begin
          st_nxt.state = ccctl_pkg::CCCTL_IO_WAIT;
          st_nxt.cnt   = gap; // hold off next access for gap clocks
        end
      end
      ccctl_pkg::CCCTL_IO_WAIT: begin
        st_nxt.cnt = st_r.cnt - CNT_W'(1);
        if (st_r.cnt == CNT_W'(1)) begin
          st_nxt.state = ccctl_pkg::CCCTL_IO_IDLE;
        end
      end
      default: begin
        st_nxt.state = ccctl_pkg::CCCTL_IO_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '{state: ccctl_pkg::CCCTL_IO_IDLE, cnt: '0};
    end else begin
      st_r <= st_nxt;
    end
  end

endmodule // ccctl_io_gap

/* ccctl_top.sv */
// Summary of operation
// - the feature control register sits at index e8, read/write, 8 bits, reset value 85.
// - bit 7 set lets the identification flag change and enables the identification instruction.
// - bit 6 set lets new management interrupts nest while already in management mode.
// - bit 5 selects floating-point fast mode, 1 enabling it.
// - bit 4 set permits directory entries to be cached, and is 0 after reset.
// - bit 3 set lets memory reads bypass earlier operations, and is 0 after reset.
// - bits 2:0 set the least bus clocks between i/o accesses: 0, 2, 4 up to 128.
// - the feature control register may be read or written only while the map enable is 1.
// - the interrupt trigger register sits at index eb, read/write, 8 bits, reset value 00.
// - writing 1 to bit 2 of the trigger register raises a non-maskable interrupt, 0 does nothing; here a 1 written over a held 1 raises none.
// - bit 0 of the trigger register set enables the extended simd instructions.
// - with map enable 0 only a small set of indexes is reachable, the rest are blocked.
//
// Strobed register access was decided locally.
`timescale 1ns/10ps
`include "ccctl_regs.svh"
module ccctl_top #(
  parameter int IO_CNT_W = 8
) (
  input  wire logic       clk,
  input  wire logic       arst_n,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  input  wire logic       config_map_enable,
  output logic            cfg_blocked,
  input  wire logic       io_req,
  output logic            io_grant,
  output logic            io_busy,
  output logic            ident_instr_enable,
  output logic            mgmt_irq_nest_enable,
  output logic            float_fast_enable,
  output logic            dir_entry_cache_enable,
  output logic            read_bypass_enable,
  output logic      [2:0] io_recovery_clocks,
  output logic            ext_simd_enable,
  output logic            nmi_pulse
);

  ////////////////////////////////////////////////////////////////////////////
  // reset release
  logic [1:0] rst_sync_r;
  logic       rst_n;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_sync_r <= 2'h0;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_r[1];

  ////////////////////////////////////////////////////////////////////////////
  // state
  typedef struct packed {
    logic [7:0] feature_control_reg;
    logic [7:0] interrupt_trigger_reg;
    logic [7:0] rdata;
  } ccctl_st_t;

  ccctl_st_t          st_r;
  ccctl_st_t          st_nxt;
  ccctl_pkg::ccctl_bus_t bus;
  ccctl_pkg::ccctl_feature_t feat;
  logic               hit_feature;
  logic               hit_trigger;
  logic               open_idx;

  assign bus = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

  // indexes that stay reachable with the map closed
  always_comb begin
    open_idx = ((bus.addr >= `CCCTL_OPEN_LO0) && (bus.addr <= `CCCTL_OPEN_HI0))
            || ((bus.addr >= `CCCTL_OPEN_LO1) && (bus.addr <= `CCCTL_OPEN_HI1))
            || ((bus.addr >= `CCCTL_OPEN_LO2) && (bus.addr <= `CCCTL_OPEN_HI2));
  end

  // both registers here lie outside the open set, so closed map blocks them
  always_comb begin
    hit_feature = 1'b0;
    hit_trigger = 1'b0;
    if (!config_map_enable) begin
      hit_feature = 1'b0;
    end else if (bus.addr == `CCCTL_IDX_FEATURE) begin
      hit_feature = 1'b1;
    end else if (bus.addr == `CCCTL_IDX_TRIGGER) begin
      hit_trigger = 1'b1;
    end
  end

  assign cfg_blocked = (bus.wr | bus.rd) & ~config_map_enable & ~open_idx;

  ////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    st_nxt       = st_r;
    st_nxt.rdata = 8'h00;
    if (bus.wr && hit_feature) begin
      st_nxt.feature_control_reg = bus.wdata;
    end
    if (bus.wr && hit_trigger) begin
      // reserved bits held at zero whatever is written
      st_nxt.interrupt_trigger_reg = bus.wdata & `CCCTL_TRIGGER_WMASK;
    end
    if (bus.rd && hit_feature) begin
      st_nxt.rdata = st_r.feature_control_reg;
    end else if (bus.rd && hit_trigger) begin
      st_nxt.rdata = st_r.interrupt_trigger_reg;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '{feature_control_reg:   `CCCTL_RST_FEATURE,
                interrupt_trigger_reg: `CCCTL_RST_TRIGGER,
                rdata:                 8'h00};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign reg_rdata = st_r.rdata;

  ////////////////////////////////////////////////////////////////////////////
  // feature outputs
  assign feat                   = st_r.feature_control_reg;
  assign ident_instr_enable     = feat.ident_instr_enable;
  assign mgmt_irq_nest_enable   = feat.mgmt_irq_nest_enable;
  assign float_fast_enable      = feat.float_fast_enable;
  assign dir_entry_cache_enable = feat.dir_entry_cache_enable;
  assign read_bypass_enable     = feat.read_bypass_enable;
  assign io_recovery_clocks     = feat.io_recovery_clocks;
  assign ext_simd_enable        = st_r.interrupt_trigger_reg[`CCCTL_BIT_SIMD];

  ////////////////////////////////////////////////////////////////////////////
  // nmi edge and i/o gap
  // a held 1 gives no repeat; software must clear first
  ccctl_nmi_pulse u_nmi (
    .clk       (clk),
    .rst_n     (rst_n),
    .trig      (st_r.interrupt_trigger_reg[`CCCTL_BIT_NMI]),
    .nmi_pulse (nmi_pulse)
  );

  ccctl_io_gap #(
    .CNT_W (IO_CNT_W)
  ) u_io_gap (
    .clk      (clk),
    .rst_n    (rst_n),
    .sel      (feat.io_recovery_clocks),
    .io_req   (io_req),
    .io_grant (io_grant),
    .io_busy  (io_busy)
  );

endmodule // ccctl_top

/* ccctl_top_asserts.sv */
`timescale 1ns/10ps
module ccctl_chk (
  input wire logic       clk,
  input wire logic       arst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       config_map_enable,
  input wire logic       cfg_blocked,
  input wire logic       io_req,
  input wire logic       io_grant,
  input wire logic       io_busy,
  input wire logic       ident_instr_enable,
  input wire logic       mgmt_irq_nest_enable,
  input wire logic       float_fast_enable,
  input wire logic       dir_entry_cache_enable,
  input wire logic       read_bypass_enable,
  input wire logic [2:0] io_recovery_clocks,
  input wire logic       ext_simd_enable,
  input wire logic       nmi_pulse
);
  logic [7:0] feat;
  logic       nmi_wr_r;
  logic       trig_sh_r;
  logic       eb_wr;
  assign feat = {ident_instr_enable, mgmt_irq_nest_enable, float_fast_enable,
                 dir_entry_cache_enable, read_bypass_enable, io_recovery_clocks};
  assign eb_wr = reg_wr && config_map_enable && reg_addr == 8'heb;
  // pulse lags the write by two edges; only a 0-to-1 write of the trigger counts
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      nmi_wr_r  <= 1'b0;
      trig_sh_r <= 1'b0;
    end else begin
      nmi_wr_r <= eb_wr && reg_wdata[2] && !trig_sh_r;
      if (eb_wr) trig_sh_r <= reg_wdata[2];
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  ////////////////////////////////////////////////////////////////////////
  property p_rd_feat; reg_rd && config_map_enable && reg_addr == 8'he8 |=> reg_rdata == feat; endproperty
  a_rd_feat: assert property (p_rd_feat) else $error("feature read wrong");
  property p_rd_trig; reg_rd && config_map_enable && reg_addr == 8'heb |=>
    reg_rdata[7:3] == 5'h00 && !reg_rdata[1] && reg_rdata[0] == ext_simd_enable; endproperty
  a_rd_trig: assert property (p_rd_trig) else $error("trigger read wrong");
  property p_rd_shut; reg_rd && !config_map_enable |=> reg_rdata == 8'h00; endproperty
  a_rd_shut: assert property (p_rd_shut) else $error("closed read not zero");
  property p_wr_feat; reg_wr && config_map_enable && reg_addr == 8'he8 |=> feat == $past(reg_wdata); endproperty
  a_wr_feat: assert property (p_wr_feat) else $error("feature write lost");
  property p_wr_shut; reg_wr && !config_map_enable |=> $stable(feat) && $stable(ext_simd_enable); endproperty
  a_wr_shut: assert property (p_wr_shut) else $error("closed write took effect");
  property p_block; (reg_wr || reg_rd) && reg_addr inside {8'he8, 8'heb} |-> cfg_blocked == !config_map_enable;
  endproperty
  a_block: assert property (p_block) else $error("blocked flag wrong");
  property p_nmi_src; nmi_pulse |-> $past(nmi_wr_r); endproperty
  a_nmi_src: assert property (p_nmi_src) else $error("nmi without trigger write");
  property p_nmi_gen; nmi_wr_r |=> nmi_pulse; endproperty
  a_nmi_gen: assert property (p_nmi_gen) else $error("trigger write gave no nmi");
  property p_nmi_one; nmi_pulse |=> !nmi_pulse; endproperty
  a_nmi_one: assert property (p_nmi_one) else $error("nmi longer than one cycle");
  property p_grant; io_grant |-> io_req && !io_busy; endproperty
  a_grant: assert property (p_grant) else $error("grant during recovery");
  property p_gap2; io_grant && io_recovery_clocks == 3'h1 |=> io_busy [*2] ##1 !io_busy; endproperty
  a_gap2: assert property (p_gap2) else $error("two clock gap wrong");
  property p_gap0; io_grant && io_recovery_clocks == 3'h0 |=> !io_busy; endproperty
  a_gap0: assert property (p_gap0) else $error("zero gap went busy");
endmodule // ccctl_chk
bind ccctl_top ccctl_chk u_chk (.clk(clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .config_map_enable(config_map_enable),
  .cfg_blocked(cfg_blocked), .io_req(io_req), .io_grant(io_grant), .io_busy(io_busy),
  .ident_instr_enable(ident_instr_enable), .mgmt_irq_nest_enable(mgmt_irq_nest_enable),
  .float_fast_enable(float_fast_enable), .dir_entry_cache_enable(dir_entry_cache_enable),
  .read_bypass_enable(read_bypass_enable), .io_recovery_clocks(io_recovery_clocks),
  .ext_simd_enable(ext_simd_enable), .nmi_pulse(nmi_pulse));

/* tb.sv */
`timescale 1ns/10ps
`define CHK(a,b) begin compares++; if ((a) !== (b)) begin err_count++; $display("CHECK FAILED %0t got %h exp %h", $time, a, b); end end
module tb;
  logic       clk = 1'b0;
  logic       arst_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic       reg_wr = 1'b0;
  logic       reg_rd = 1'b0;
  logic       map_en = 1'b1;
  logic       io_req = 1'b0;
  logic       rd_d = 1'b0;
  logic [7:0] reg_rdata, cur, exp_v;
  wire  [7:0] feat;
  logic       open_v;
  logic       cfg_blocked, io_grant, io_busy, ext_simd_enable, nmi_pulse;
  logic [7:0] q[$];
  int         err_count = 0, compares = 0, pulses = 0, n;
  always #5 clk = ~clk;
  ccctl_top #(.IO_CNT_W(8)) uut (.clk(clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .config_map_enable(map_en),
    .cfg_blocked(cfg_blocked), .io_req(io_req), .io_grant(io_grant), .io_busy(io_busy),
    .ident_instr_enable(feat[7]), .mgmt_irq_nest_enable(feat[6]), .float_fast_enable(feat[5]),
    .dir_entry_cache_enable(feat[4]), .read_bypass_enable(feat[3]), .io_recovery_clocks(feat[2:0]),
    .ext_simd_enable(ext_simd_enable), .nmi_pulse(nmi_pulse));
  ////////////////////////////////////////////////////////////////////////
  task automatic test_done;
    if (err_count == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  // expectation queued with the strobe, checked when data lands
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    q.push_back(e);
    @(posedge clk);
    reg_rd <= 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////////////
  always @(posedge clk) rd_d <= reg_rd;
  always @(negedge clk) begin
    if (rd_d) begin
      exp_v = q.pop_front();
      `CHK(reg_rdata, exp_v)
    end
    if (reg_rd || reg_wr) begin
      open_v = reg_addr inside {[8'hc1:8'hc3], [8'hcd:8'hcf], [8'hfe:8'hff]};
      `CHK(cfg_blocked, !map_en && !open_v)
    end
    if (nmi_pulse === 1'b1) pulses++;
  end
  initial begin
    #100us;
    err_count++;
    test_done;
  end
  initial begin
    void'($urandom(68781));
    repeat (12) @(posedge clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk);
    rd(8'he8, 8'h85);
    rd(8'heb, 8'h00);
    `CHK(feat, 8'h85)
    for (int c = 0; c < 8; c++) begin
      cur = 8'($urandom());
      cur[2:0] = c[2:0];
      wr(8'he8, cur);
      rd(8'he8, cur);
      `CHK(feat, cur)
      @(posedge clk);
      io_req <= 1'b1;
      @(negedge clk);
      `CHK(io_grant, 1'b1)
      @(posedge clk);
      io_req <= 1'b0;
      n = 0;
      repeat (200) begin
        @(negedge clk);
        if (io_busy === 1'b1) n++;
      end
      `CHK(n, (c == 0) ? 0 : (1 << c))
    end
    // map closed: both indexes must ignore writes and read zero
    @(posedge clk);
    map_en <= 1'b0;
    wr(8'he8, ~cur);
    wr(8'heb, 8'h05);
    rd(8'he8, 8'h00);
    rd(8'heb, 8'h00);
    rd(8'hcd, 8'h00);
    @(posedge clk);
    map_en <= 1'b1;
    rd(8'he8, cur);
    `CHK(pulses, 0)
    wr(8'heb, 8'h05);
    rd(8'heb, 8'h05);
    wr(8'heb, 8'h05);
    wr(8'heb, 8'h01);
    wr(8'heb, 8'h04);
    repeat (3) @(posedge clk);
    `CHK(pulses, 2)
    `CHK(ext_simd_enable, 1'b0)
    test_done;
  end
endmodule // tb
